// File: bench/i2c_tenbit_slave_multimaster_arbiter_bench.sv
/*
 Testbench for its_core: 10-bit slave receive, stop, start and send collisions.
 Assumes the far-side master model and the bound checker.
*/
`timescale 1ns/10ps
`default_nettype none
module i2c_tenbit_slave_multimaster_arbiter_bench;
    logic core_clk, resetn, module_enable, address_write, buffer_read, buffer_write;
    logic stretch_enable, address_hold_enable, data_hold_enable, clock_release_set;
    logic irq_flag_clear, collision_flag_clear, start_request, sleep_mode, irq_enable;
    logic scl_out, scl_oe, sda_out, sda_oe, buffer_full_flag, update_address_flag;
    logic clock_release_bit, serial_irq_flag, collision_irq_flag, start_detected;
    logic stop_detected, start_busy, wake_request, m_scl_oe, m_sda_oe, watch, bf_q, ack;
    logic [7:0] address_wdata, slave_address_reg, buffer_wdata, serial_buffer, hi, lo, d;
    wire logic scl_in = !(scl_oe | m_scl_oe);
    wire logic sda_in = !(sda_oe | m_sda_oe);
    integer errors, check_count, seed, n;
    logic [7:0] q[$];
    its_core uut (.*);
    its_bus_master m (.scl(scl_in), .sda(sda_in), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check1
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check8
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic settle;
        repeat (8) @(negedge core_clk);
    endtask : settle
    // Pulses: start, write, read, irq clear, release, collision clear
    task automatic fw(input logic [5:0] v);
        @(negedge core_clk);
        {start_request, buffer_write, buffer_read, irq_flag_clear, clock_release_set,
            collision_flag_clear} = v;
        @(negedge core_clk);
        {start_request, buffer_write, buffer_read, irq_flag_clear, clock_release_set,
            collision_flag_clear} = 6'h00;
    endtask : fw
    task automatic fw_addr(input logic [7:0] a);
        @(negedge core_clk);
        address_wdata = a;
        address_write = 1'b1;
        @(negedge core_clk);
        address_write = 1'b0;
    endtask : fw_addr
    always @(negedge core_clk) begin
        if (watch && buffer_full_flag === 1'b1 && bf_q !== 1'b1 && q.size() > 0)
            check8(serial_buffer, q.pop_front());
        bf_q <= buffer_full_flag;
    end
    // Run near 30 us; wide margin
    initial begin
        #1_000_000;
        errors++;
        test_done;
    end
    initial begin
        {start_request, buffer_write, buffer_read, irq_flag_clear, clock_release_set,
            collision_flag_clear, address_write, sleep_mode, irq_enable, watch} = 10'h000;
        {address_hold_enable, data_hold_enable, stretch_enable} = 3'h0;
        {address_wdata, buffer_wdata} = 16'h0000;
        errors = 0;
        check_count = 0;
        seed = 32'hEBC98D5A;
        module_enable = 1'b1;
        resetn = 1'b0;
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        check1(clock_release_bit, 1'b1);
        check8(slave_address_reg, 8'h00);
        check1(start_detected | stop_detected, 1'b0);
        hi = {5'b11110, 2'($random(seed)), 1'b0};
        lo = 8'($random(seed));
        fw_addr(hi);
        stretch_enable = 1'b1;
        watch = 1'b1;
        m.start_cond();
        q.push_back(hi);
        m.send_byte(hi, ack);
        settle;
        check1(ack, 1'b1);
        check1(update_address_flag, 1'b1);
        check1(serial_irq_flag, 1'b1);
        check1(scl_oe, 1'b1);
        fw(6'h0C);
        fw_addr(lo);
        q.push_back(lo);
        m.send_byte(lo, ack);
        settle;
        check1(ack, 1'b1);
        check1(serial_irq_flag, 1'b1);
        fw(6'h0C);
        fw_addr(hi);
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            sleep_mode = (k == 2);
            irq_enable = (k == 2);
            q.push_back(d);
            m.send_byte(d, ack);
            settle;
            check1(ack, 1'b1);
            check1(clock_release_bit, 1'b0);
            check1(scl_oe, 1'b1);
            check1(wake_request, k == 2);
            fw(6'h0E);
        end
        sleep_mode = 1'b0;
        m.stop_cond();
        settle;
        check1(stop_detected, 1'b1);
        check1(serial_irq_flag, 1'b1);
        fw(6'h04);
        $display("Test receive done");
        m.start_cond();
        q.push_back(hi);
        m.send_byte(hi, ack);
        settle;
        fw(6'h0C);
        fw_addr(lo);
        m.send_byte(lo ^ 8'h01, ack);
        settle;
        check1(ack, 1'b0);
        check1(update_address_flag & serial_irq_flag, 1'b1);
        check1(buffer_full_flag, 1'b0);
        check1(clock_release_bit, 1'b1);
        m.stop_cond();
        fw(6'h04);
        watch = 1'b0;
        $display("Test low mismatch done");
        m.hold_sda(1'b1);
        settle;
        fw(6'h20);
        settle;
        check1(collision_irq_flag, 1'b1);
        check1(start_busy, 1'b0);
        m.hold_sda(1'b0);
        settle;
        fw(6'h05);
        settle;
        fw(6'h20);
        settle;
        for (n = 0; n < 200 && start_busy === 1'b1; n++) @(negedge core_clk);
        check1(collision_irq_flag, 1'b0);
        check1(scl_in | sda_in, 1'b0);
        m.hold_sda(1'b1);
        buffer_wdata = 8'h80 | 8'($random(seed));
        fw(6'h10);
        for (n = 0; n < 200 && collision_irq_flag !== 1'b1; n++) @(negedge core_clk);
        settle;
        check1(collision_irq_flag, 1'b1);
        check1(buffer_full_flag, 1'b0);
        check1(scl_oe | sda_oe, 1'b0);
        fw(6'h05);
        m.stop_cond();
        settle;
        check1(serial_irq_flag, 1'b1);
        module_enable = 1'b0;
        settle;
        check1(start_detected | stop_detected, 1'b0);
        $display("Test collision done");
        test_done;
    end
endmodule : i2c_tenbit_slave_multimaster_arbiter_bench
`default_nettype wire

// File: bench/its_bus_master.sv
/*
 Behavioural far-side bus master: start, stop, byte with ack sampling.
 Assumes pull-ups on both wires and a 320 ns bit period.
*/
`timescale 1ns/10ps
`default_nettype none
module its_bus_master (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_oe,
    output var  logic sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic hold_sda(input logic v);
        sda_oe = v;
    endtask : hold_sda
    task automatic bit_cycle(input logic b, output logic r);
        sda_oe = ~b;
        #80;
        scl_oe = 1'b0;
        while (scl !== 1'b1) #40;
        #160;
        r = sda;
        scl_oe = 1'b1;
        #80;
    endtask : bit_cycle
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], r);
        bit_cycle(1'b1, r);
        ack = ~r;
    endtask : send_byte
    task automatic start_cond;
        sda_oe = 1'b1;
        #160;
        scl_oe = 1'b1;
        #80;
    endtask : start_cond
    task automatic stop_cond;
        scl_oe = 1'b1;
        sda_oe = 1'b1;
        #80;
        scl_oe = 1'b0;
        #160;
        sda_oe = 1'b0;
        #160;
    endtask : stop_cond
endmodule : its_bus_master
`default_nettype wire

// File: bench/its_monitor.sv
/*
 Checker for the two-wire port core, bound into its_core.
 Assumes it sees only the core's ports, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module its_monitor (
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic       module_enable,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       address_write,
    input wire logic [7:0] address_wdata,
    input wire logic [7:0] slave_address_reg,
    input wire logic       update_address_flag,
    input wire logic       clock_release_set,
    input wire logic       clock_release_bit,
    input wire logic       irq_flag_clear,
    input wire logic       serial_irq_flag,
    input wire logic       collision_flag_clear,
    input wire logic       collision_irq_flag,
    input wire logic       start_detected,
    input wire logic       stop_detected,
    input wire logic       start_busy,
    input wire logic       sleep_mode,
    input wire logic       irq_enable,
    input wire logic       wake_request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_off_quiet: assert property (!module_enable |=> !start_detected && !stop_detected
        && clock_release_bit) else $error("status bits not cleared while off");
    a_off_release: assert property (!module_enable |=> !scl_oe && !sda_oe)
        else $error("lines driven while off");
    a_wake_cause: assert property (wake_request |-> $past(sleep_mode && irq_enable))
        else $error("wake without sleep and enable");
    a_stretch_hold: assert property (!clock_release_bit && $past(!clock_release_bit)
        |-> scl_oe) else $error("clock not held while release bit clear");
    a_release_set: assert property (clock_release_set |=> clock_release_bit)
        else $error("release bit not set");
    a_addr_load: assert property (address_write |=> slave_address_reg == $past(address_wdata)
        && !update_address_flag) else $error("address write not taken");
    a_irq_sticky: assert property (serial_irq_flag && !irq_flag_clear |=> serial_irq_flag)
        else $error("interrupt flag dropped by itself");
    a_col_sticky: assert property (collision_irq_flag && !collision_flag_clear
        |=> collision_irq_flag) else $error("collision flag dropped by itself");
    a_col_idle: assert property ($rose(collision_irq_flag) |-> ##[0:1]
        !scl_oe && !sda_oe && !start_busy) else $error("lines held after collision");
    a_stop_start: assert property ($rose(stop_detected) |-> !start_detected)
        else $error("start bit kept after stop");
    c_collision: cover property ($rose(collision_irq_flag));
    c_addr: cover property ($rose(update_address_flag));
    c_wake: cover property ($rose(wake_request));
endmodule : its_monitor
bind its_core its_monitor u_mon (.*);
`default_nettype wire

// File: logic/its_core.sv
/*
 Two-wire port core: 10-bit slave receive with stretching, sleep wake,
 bus monitoring, master start and byte send with collision detection.
 Assumes open-drain pins resolved outside; control bits are plain ports.
*/
`include "its_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module its_core #(
    parameter int         BAUD_W      = 8,
    parameter [BAUD_W-1:0] BAUD_RELOAD = `ITS_BAUD_RELOAD
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       module_enable,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       scl_out,
    output var  logic       scl_oe,
    output var  logic       sda_out,
    output var  logic       sda_oe,
    input  wire logic       address_write,
    input  wire logic [7:0] address_wdata,
    output var  logic [7:0] slave_address_reg,
    input  wire logic       buffer_read,
    input  wire logic       buffer_write,
    input  wire logic [7:0] buffer_wdata,
    output var  logic [7:0] serial_buffer,
    output var  logic       buffer_full_flag,
    output var  logic       update_address_flag,
    input  wire logic       stretch_enable,
    input  wire logic       address_hold_enable,
    input  wire logic       data_hold_enable,
    input  wire logic       clock_release_set,
    output var  logic       clock_release_bit,
    input  wire logic       irq_flag_clear,
    output var  logic       serial_irq_flag,
    input  wire logic       collision_flag_clear,
    output var  logic       collision_irq_flag,
    output var  logic       start_detected,
    output var  logic       stop_detected,
    input  wire logic       start_request,
    output var  logic       start_busy,
    input  wire logic       sleep_mode,
    input  wire logic       irq_enable,
    output var  logic       wake_request
);
    logic [1:0]             pins_s;
    logic                   scl_s, sda_s, scl_q, sda_q, rise, fall, start_c, stop_c, hit;
    logic                   set_irq, set_bcl, clr_bf, set_bf, next_bf, next_ua, ua_hold;
    logic                   next_ua_hold, next_ckp, next_irqf, next_bclf, next_sflag, next_pflag;
    logic                   ack_drv, next_ack_drv, collided, next_collided, m_sda, next_m_sda;
    logic                   next_start_busy, next_scl_oe, next_sda_oe, next_wake;
    its_pkg::its_slave_t    sstate, next_sstate;
    its_pkg::its_master_t   mstate, next_mstate;
    logic [3:0]             bitcnt, next_bitcnt, mbit, next_mbit;
    logic [7:0]             shreg, next_shreg, txsh, next_txsh, next_sar, next_buffer;
    logic [BAUD_W-1:0]      bcnt, next_bcnt;

    its_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk      (core_clk),
        .resetn   (resetn),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    assign rise    = scl_s & ~scl_q;
    assign fall    = ~scl_s & scl_q;
    assign start_c = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_c  = scl_s & scl_q & ~sda_q & sda_s;

    always_comb begin
        next_sstate     = sstate;
        next_mstate     = mstate;
        next_bitcnt     = bitcnt;
        next_shreg      = shreg;
        next_sar        = slave_address_reg;
        next_buffer     = serial_buffer;
        next_ua         = update_address_flag;
        next_ua_hold    = ua_hold;
        next_ckp        = clock_release_bit;
        next_sflag      = start_detected;
        next_pflag      = stop_detected;
        next_ack_drv    = ack_drv;
        next_collided   = collided;
        next_bcnt       = bcnt;
        next_txsh       = txsh;
        next_mbit       = mbit;
        next_m_sda      = m_sda;
        next_start_busy = start_busy;
        set_irq         = 1'b0;
        set_bcl         = 1'b0;
        set_bf          = 1'b0;
        clr_bf          = buffer_read;
        hit             = 1'b0;
        if (start_c) begin
            next_sflag   = 1'b1;
            next_pflag   = 1'b0;
            next_sstate  = its_pkg::SL_ADDR_HI;
            next_bitcnt  = 4'hF; // Start's own fall wraps to zero
            next_ack_drv = 1'b0;
        end else if (stop_c) begin
            next_pflag    = 1'b1;
            next_sflag    = 1'b0;
            next_sstate   = its_pkg::SL_IDLE;
            next_ack_drv  = 1'b0;
            next_collided = 1'b0;
            if (start_detected || collided) begin
                set_irq = 1'b1;
            end
        end else if (sstate != its_pkg::SL_IDLE && sstate != its_pkg::SL_IGNORE) begin
            if (rise && bitcnt < `ITS_BYTE_BITS) begin
                next_shreg = {shreg[6:0], sda_s};
            end
            if (fall && bitcnt == `ITS_LAST_BIT) begin
                next_bitcnt = `ITS_BYTE_BITS;
                unique case (sstate)
                    its_pkg::SL_ADDR_HI: hit = (shreg[7:1] == slave_address_reg[7:1])
                                             & ~shreg[`ITS_RW_BIT];
                    its_pkg::SL_ADDR_LO: hit = (shreg == slave_address_reg);
                    default:             hit = 1'b1;
                endcase
                next_ack_drv = hit;
                // Hold before the acknowledge, as in the 7-bit modes
                if (hit && ((sstate == its_pkg::SL_DATA) ? data_hold_enable
                                                         : address_hold_enable)) begin
                    next_ckp = 1'b0;
                    set_irq  = 1'b1;
                end
            end else if (fall && bitcnt == `ITS_BYTE_BITS) begin
                next_bitcnt  = 4'h0;
                next_ack_drv = 1'b0;
                set_irq      = ack_drv | (sstate == its_pkg::SL_ADDR_LO);
                unique case (sstate)
                    its_pkg::SL_ADDR_HI: begin
                        if (ack_drv) begin
                            next_ua      = 1'b1;
                            next_ua_hold = 1'b1;
                            next_buffer  = shreg;
                            set_bf       = 1'b1;
                            next_sstate  = its_pkg::SL_ADDR_LO;
                        end else begin
                            next_sstate  = its_pkg::SL_IGNORE;
                        end
                    end
                    its_pkg::SL_ADDR_LO: begin
                        next_ua = 1'b1;
                        if (ack_drv) begin
                            next_ua_hold = 1'b1;
                            next_buffer  = shreg;
                            set_bf       = 1'b1;
                            next_sstate  = its_pkg::SL_DATA;
                        end else begin
                            next_sstate  = its_pkg::SL_IGNORE;
                        end
                    end
                    default: begin
                        next_buffer = shreg;
                        set_bf      = 1'b1;
                        if (stretch_enable) begin
                            next_ckp = 1'b0;
                        end
                    end
                endcase
            end else if (fall) begin
                next_bitcnt = bitcnt + 4'h1;
            end
        end
        if (address_write) begin
            next_sar     = address_wdata;
            next_ua      = 1'b0;
            next_ua_hold = 1'b0;
        end
        if (clock_release_set) begin
            next_ckp = 1'b1;
        end
        if (buffer_write) begin
            next_txsh = buffer_wdata;
            next_mbit = 4'h0;
            set_bf    = 1'b1;
        end
        unique case (mstate)
            its_pkg::MS_IDLE: begin
                next_m_sda = 1'b0;
                if (start_request) begin
                    if (!scl_s || !sda_s) begin
                        set_bcl = 1'b1;
                    end else begin
                        next_start_busy = 1'b1;
                        next_bcnt       = BAUD_RELOAD;
                        next_mstate     = its_pkg::MS_START_A;
                    end
                end
            end
            its_pkg::MS_START_A: begin
                if (!scl_s && sda_s) begin
                    set_bcl = 1'b1;
                end else if (!sda_s || bcnt == '0) begin
                    next_m_sda  = 1'b1;
                    next_bcnt   = BAUD_RELOAD;
                    next_mstate = its_pkg::MS_START_B;
                end else begin
                    next_bcnt = bcnt - 1'b1;
                end
            end
            its_pkg::MS_START_B: begin
                // Clock low here is not a collision
                if (bcnt == '0) begin
                    next_start_busy = 1'b0;
                    next_mstate     = its_pkg::MS_HOLD;
                end else begin
                    next_bcnt = bcnt - 1'b1;
                end
            end
            its_pkg::MS_HOLD: begin
                if (buffer_write) begin
                    next_bcnt   = BAUD_RELOAD;
                    next_mstate = its_pkg::MS_LOW;
                end
            end
            its_pkg::MS_LOW: begin
                next_m_sda = (mbit == `ITS_BYTE_BITS) ? 1'b0 : ~txsh[7];
                if (bcnt == '0) begin
                    next_bcnt   = BAUD_RELOAD;
                    next_mstate = its_pkg::MS_HIGH;
                end else begin
                    next_bcnt = bcnt - 1'b1;
                end
            end
            its_pkg::MS_HIGH: begin
                // Counts only while the wire is high: clock sync with other masters
                if (scl_s && bcnt != '0) begin
                    next_bcnt = bcnt - 1'b1;
                end else if (scl_s) begin
                    if (!m_sda && !sda_s && mbit != `ITS_BYTE_BITS) begin
                        set_bcl = 1'b1;
                        clr_bf  = 1'b1;
                    end else if (mbit == `ITS_BYTE_BITS) begin
                        set_irq     = 1'b1;
                        clr_bf      = 1'b1;
                        next_mbit   = 4'h0;
                        next_m_sda  = 1'b1;
                        next_mstate = its_pkg::MS_HOLD;
                    end else begin
                        next_txsh   = {txsh[6:0], 1'b0};
                        next_mbit   = mbit + 4'h1;
                        next_bcnt   = BAUD_RELOAD;
                        next_mstate = its_pkg::MS_LOW;
                    end
                end
            end
        endcase
        if (set_bcl) begin
            next_mstate     = its_pkg::MS_IDLE;
            next_m_sda      = 1'b0;
            next_start_busy = 1'b0;
            next_collided   = 1'b1;
            next_mbit       = 4'h0;
        end
        // Disabled: all idle
        if (!module_enable) begin
            next_sstate     = its_pkg::SL_IDLE;
            next_mstate     = its_pkg::MS_IDLE;
            next_sflag      = 1'b0;
            next_pflag      = 1'b0;
            next_ack_drv    = 1'b0;
            next_m_sda      = 1'b0;
            next_ua_hold    = 1'b0;
            next_ckp        = 1'b1;
            next_start_busy = 1'b0;
            next_collided   = 1'b0;
            next_bitcnt     = 4'h0;
        end
        // Hardware set wins over a same-cycle clear
        next_bf   = set_bf | (buffer_full_flag & ~clr_bf);
        next_irqf = set_irq | (serial_irq_flag & ~irq_flag_clear);
        next_bclf = set_bcl | (collision_irq_flag & ~collision_flag_clear);
        next_sda_oe = next_ack_drv | next_m_sda;
        next_scl_oe = ~next_ckp | next_ua_hold
                    | (next_mstate == its_pkg::MS_HOLD) | (next_mstate == its_pkg::MS_LOW);
        next_wake   = sleep_mode & irq_enable & next_irqf;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_q               <= 1'b1;
            sda_q               <= 1'b1;
            sstate              <= its_pkg::SL_IDLE;
            mstate              <= its_pkg::MS_IDLE;
            bitcnt              <= 4'h0;
            shreg               <= 8'h00;
            slave_address_reg   <= `ITS_SAR_RESET;
            serial_buffer       <= `ITS_BUF_RESET;
            buffer_full_flag    <= 1'b0;
            update_address_flag <= 1'b0;
            ua_hold             <= 1'b0;
            clock_release_bit   <= 1'b1;
            serial_irq_flag     <= 1'b0;
            collision_irq_flag  <= 1'b0;
            start_detected      <= 1'b0;
            stop_detected       <= 1'b0;
            ack_drv             <= 1'b0;
            collided            <= 1'b0;
            bcnt                <= '0;
            txsh                <= 8'h00;
            mbit                <= 4'h0;
            m_sda               <= 1'b0;
            start_busy          <= 1'b0;
            scl_oe              <= 1'b0;
            sda_oe              <= 1'b0;
            scl_out             <= 1'b0;
            sda_out             <= 1'b0;
            wake_request        <= 1'b0;
        end else begin
            scl_q               <= scl_s;
            sda_q               <= sda_s;
            sstate              <= next_sstate;
            mstate              <= next_mstate;
            bitcnt              <= next_bitcnt;
            shreg               <= next_shreg;
            slave_address_reg   <= next_sar;
            serial_buffer       <= next_buffer;
            buffer_full_flag    <= next_bf;
            update_address_flag <= next_ua;
            ua_hold             <= next_ua_hold;
            clock_release_bit   <= next_ckp;
            serial_irq_flag     <= next_irqf;
            collision_irq_flag  <= next_bclf;
            start_detected      <= next_sflag;
            stop_detected       <= next_pflag;
            ack_drv             <= next_ack_drv;
            collided            <= next_collided;
            bcnt                <= next_bcnt;
            txsh                <= next_txsh;
            mbit                <= next_mbit;
            m_sda               <= next_m_sda;
            start_busy          <= next_start_busy;
            scl_oe              <= next_scl_oe;
            sda_oe              <= next_sda_oe;
            scl_out             <= 1'b0;
            sda_out             <= 1'b0;
            wake_request        <= next_wake;
        end
    end
endmodule : its_core
`default_nettype wire

// File: logic/its_pkg.sv
/*
 Types of the two-wire port: slave and master sequencer states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package its_pkg;
    typedef enum logic [2:0] {
        SL_IDLE,
        SL_ADDR_HI,
        SL_ADDR_LO,
        SL_DATA,
        SL_IGNORE
    } its_slave_t;
    typedef enum logic [2:0] {
        MS_IDLE,
        MS_START_A,
        MS_START_B,
        MS_HOLD,
        MS_LOW,
        MS_HIGH
    } its_master_t;
endpackage : its_pkg

// File: logic/its_regs.svh
/*
 Constants for the two-wire slave and multi-master port: field positions,
 reset values and timing counts. Assumes inclusion by the core.
*/
// What this block does
// - Matching high address byte, write: set update-address flag, acknowledge, raise interrupt.
// - Clock held low after high byte until firmware writes the slave address.
// - Low byte mismatch: set interrupt and update-address, no buffer-full, release bit untouched.
// - Low byte match: acknowledge, interrupt, address into buffer; buffer read clears full.
// - Each received data byte acknowledged on ninth pulse, then interrupt flag set.
// - Stretch enabled: hardware clears release bit per data byte; firmware sets it to free clock.
// - Address or data hold stretches as in 7-bit modes, plus address updates.
// - In sleep, receive continues; match or byte wakes processor if interrupt enabled.
// - Device reset disables the port and aborts any transfer.
// - Start and stop detected bits cleared by reset and while disabled.
// - Bus busy: a detected stop raises the interrupt flag.
// - Master sending released one but sampling zero sets collision and goes idle.
// - Arbitration checked during start and the eight bits of each sent byte; not during acknowledge.
// - Transmit collision halts transfer, clears buffer-full, releases lines, accepts writes.
// - Condition collision aborts it, releases lines, clears its control bit.
// - After collision, keep watching lines; stop sets the interrupt flag.
// - Buffer write after collision loads the byte and sets full but starts no transfer.
// - Start request with either line low aborts, sets collision, goes idle.
// - Start waits data high, loads baud count; clock low then is collision.
// - Data low in count: drive data early; else drive data, recount, drive clock.
`ifndef ITS_REGS_SVH
`define ITS_REGS_SVH
`define ITS_RW_BIT      0
`define ITS_BYTE_BITS   4'h8
`define ITS_LAST_BIT    4'h7
`define ITS_SAR_RESET   8'h00
`define ITS_BUF_RESET   8'h00
`define ITS_BAUD_RELOAD 8'h04
`endif

// File: logic/its_sync.sv
/*
 Two-flop synchroniser, one lane per bit.
 Assumes inputs are asynchronous to clk; first stage feeds only the second.
*/
`timescale 1ns/10ps
`default_nettype none
module its_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            // Idle bus level is high, so reset to one
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    stage1[i]   <= 1'b1;
                    sync_out[i] <= 1'b1;
                end else begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : its_sync
`default_nettype wire
